/* logic/spb_buf.v */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`include "spb_map.vh"

module spb_buf
(
	// clock and reset
	input wire clk,
	input wire rst_n,
	// filling side
	input wire in_valid,
	input wire [`SPB_DATA_W-1:0] in_data,
	output reg in_ready,
	// draining side
	output wire out_valid,
	output wire [`SPB_DATA_W-1:0] out_data,
	input wire out_ready
);

reg [`SPB_DATA_W-1:0] mem [0:1];
reg wr_ptr;
reg rd_ptr;
reg [1:0] count;
wire push;
wire pop;
reg [1:0] next_count;

assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;
assign out_valid = (count != 2'h0);
assign out_data = mem[rd_ptr];

always @*
begin
	next_count = count;
	if (push & ~pop)
		next_count = count + 2'h1;
	else if (pop & ~push)
		next_count = count - 2'h1;
end

always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		wr_ptr <= 1'b0;
		rd_ptr <= 1'b0;
		count <= 2'h0;
		in_ready <= 1'b0;
	end
	else
	begin
		if (push)
			wr_ptr <= ~wr_ptr;
		if (pop)
			rd_ptr <= ~rd_ptr;
		count <= next_count;
		// registered ready: full means no room next cycle
		in_ready <= (next_count != 2'h2);
	end
end

// storage has no reset; contents are qualified by count
always @(posedge clk)
begin
	if (push)
		mem[wr_ptr] <= in_data;
end

endmodule

/* logic/spb_map.vh */
// constants for the system bus parity, arbitration and host pin block
`ifndef SPB_MAP_VH
`define SPB_MAP_VH

// data bus shape
`define SPB_DATA_W 64
`define SPB_LANES 8
`define SPB_LANE_W 8
`define SPB_LANE_IDX_W 3

// pins that turn into host port pins when the host port is on
`define SPB_SHARED_LO 32
// pins used only in full-width bus mode
`define SPB_TOP_LO 61
`define SPB_TOP_HI 63

// beats per tenure
`define SPB_BEATS_SINGLE 3'h1
`define SPB_BEATS_BURST 3'h4
`define SPB_BEAT_CNT_W 3

// reset values and the lane mask for host mode
`define SPB_ALL_RELEASED_DATA 64'hffffffffffffffff
`define SPB_ALL_RELEASED_PAR 8'hff
`define SPB_ZERO_DATA 64'h0000000000000000
`define SPB_ZERO_PAR 8'h00
`define SPB_LOW_LANES_ON 8'hf0
`define SPB_BEAT_ZERO 3'h0

`endif

/* logic/spb_top.v */
// system bus data, parity, arbiter grants and shared host port pins
`timescale 1ns/1ns
`include "spb_map.vh"

// What this block does
// - as master in writes device drives data; in reads the slave drives it
// - data pins 61 to 63 used only in full-width mode with host port off
// - the data driver also drives each parity line giving odd ones count
// - parity lines 0 to 3 cover data bits 0-7, 8-15, 16-23, 24-31
// - parity lines 4 to 7 continue lanes, last covers bits 56-63
// - arbiter asserts matching bus grant to hand over the address bus
// - a separate data bus grant per external master gives the data bus
// - transfer ack marks each beat; single ends on one, burst on fourth
// - host port on makes shared upper pins stop being system bus data
// - host port selected when either of its two selects is active
// - width select picks an 8-bit or 16-bit host data path
// - an input picks one combined strobe or separate read and write strobes
// - a polarity input sets host strobes as active high or active low
// - dual request mode drives receive request, programmable polarity and open drain
// - single request mode samples host acknowledge with programmable polarity

module spb_top
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// own transfer commands
	input wire cmd_valid,
	input wire cmd_write,
	input wire cmd_burst,
	output reg cmd_ready,
	// write data stream
	input wire wr_valid,
	input wire [`SPB_DATA_W-1:0] wr_data,
	output wire wr_ready,
	// read data and tenure end
	output reg rd_valid,
	output reg [`SPB_DATA_W-1:0] rd_data,
	output reg [`SPB_LANES-1:0] rd_parity_error,
	output reg tenure_done,
	// bus configuration
	input wire full_width_bus_only_mode,
	input wire host_port_enable,
	// data bus pins, index n is data bit n
	input wire [`SPB_DATA_W-1:0] data_in,
	output reg [`SPB_DATA_W-1:0] data_out,
	output reg [`SPB_DATA_W-1:0] data_oe_n,
	// parity pins, index n is data_parity_lane n
	input wire [`SPB_LANES-1:0] data_parity_in,
	output reg [`SPB_LANES-1:0] data_parity_out,
	output reg [`SPB_LANES-1:0] data_parity_oe_n,
	input wire transfer_ack,
	// arbitration
	input wire ext_master_request_a,
	input wire ext_master_request_b,
	input wire ext_tenure_burst,
	output reg ext_master_grant_a,
	output reg ext_master_grant_b,
	output reg ext_master_data_grant_a,
	output reg ext_master_data_grant_b,
	// host port pins
	input wire host_select_a,
	input wire host_select_b,
	input wire host_width_select,
	input wire host_dual_strobe_select,
	input wire host_strobe_polarity,
	input wire host_data_strobe,
	input wire host_write_strobe,
	input wire host_read_write,
	input wire host_acknowledge,
	// host request programming
	input wire host_dual_request_mode,
	input wire host_request_polarity,
	input wire host_request_open_drain,
	input wire host_ack_polarity,
	input wire host_tx_pending,
	input wire host_rx_pending,
	// host port status and request pins
	output reg host_selected,
	output reg host_width_8,
	output reg host_read_active,
	output reg host_write_active,
	output reg host_ack_seen,
	output reg host_request_out,
	output reg host_request_oe_n,
	output reg host_receive_request_out,
	output reg host_receive_request_oe_n
);

localparam ST_IDLE = 4'b0001;
localparam ST_OWN = 4'b0010;
localparam ST_EXT_ADDR = 4'b0100;
localparam ST_EXT_DATA = 4'b1000;

// odd parity bit for one byte lane
function spb_odd_par;
	input [`SPB_LANE_W-1:0] lane;
	begin
		spb_odd_par = ~(^lane);
	end
endfunction

// pins that carry system data in the present mode
function [`SPB_DATA_W-1:0] spb_data_mask;
	input host_en;
	input full_width;
	integer i;
	begin
		spb_data_mask = `SPB_ALL_RELEASED_DATA;
		for (i = `SPB_SHARED_LO; i < `SPB_DATA_W; i = i + 1)
			if (host_en)
				spb_data_mask[i] = 1'b0;
		for (i = `SPB_TOP_LO; i <= `SPB_TOP_HI; i = i + 1)
			if (host_en || !full_width)
				spb_data_mask[i] = 1'b0;
	end
endfunction

// pin level seen as asserted under a polarity choice, 1 means active high
function spb_active;
	input level;
	input pol;
	begin
		spb_active = pol ? level : ~level;
	end
endfunction

reg rst_meta;
reg rst_n;
reg [3:0] state;
reg [3:0] next_state;
reg own_write;
reg burst;
reg owner_b;
reg drive_valid;
reg [`SPB_BEAT_CNT_W-1:0] beat_cnt;
wire [`SPB_DATA_W-1:0] mask;
wire [`SPB_LANES-1:0] lane_on;
wire [`SPB_BEAT_CNT_W-1:0] beats_needed;
wire last_beat;
wire own_ack;
wire buf_valid;
wire [`SPB_DATA_W-1:0] buf_data;
wire buf_pop;
wire own_start;
wire [`SPB_DATA_W-1:0] rd_masked;
reg [`SPB_LANES-1:0] next_par;
reg [`SPB_LANES-1:0] next_perr;
integer n;

// reset released through two flops
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		rst_meta <= 1'b0;
		rst_n <= 1'b0;
	end
	else
	begin
		rst_meta <= 1'b1;
		rst_n <= rst_meta;
	end
end

// shared pins leave the data bus
assign mask = spb_data_mask(host_port_enable, full_width_bus_only_mode);
assign lane_on = host_port_enable ? ~`SPB_LOW_LANES_ON : `SPB_ALL_RELEASED_PAR;

assign beats_needed = burst ? `SPB_BEATS_BURST : `SPB_BEATS_SINGLE;
assign last_beat = (beat_cnt == beats_needed - `SPB_BEATS_SINGLE);
// a write beat counts only once our word is on the pins
assign own_ack = transfer_ack && state == ST_OWN && (!own_write || drive_valid);
assign buf_pop = own_ack && own_write;
// internal master ranks below both external masters
assign own_start = cmd_valid && !cmd_ready && (!cmd_write || buf_valid);
assign rd_masked = data_in & mask;

spb_buf u_buf
(
	.clk(clk),
	.rst_n(rst_n),
	.in_valid(wr_valid),
	.in_data(wr_data),
	.in_ready(wr_ready),
	.out_valid(buf_valid),
	.out_data(buf_data),
	.out_ready(buf_pop)
);

always @*
begin
	next_state = state;
	case (state)
		ST_IDLE:
		begin
			if (ext_master_request_a || ext_master_request_b)
				next_state = ST_EXT_ADDR;
			else if (own_start)
				next_state = ST_OWN;
		end
		ST_OWN:
		begin
			if (own_ack && last_beat)
				next_state = ST_IDLE;
		end
		ST_EXT_ADDR:
		begin
			// address tenure ends when the owner drops its request
			if (!(owner_b ? ext_master_request_b : ext_master_request_a))
				next_state = ST_EXT_DATA;
		end
		ST_EXT_DATA:
		begin
			if (transfer_ack && last_beat)
				next_state = ST_IDLE;
		end
		default:
			next_state = ST_IDLE;
	endcase
end

// lane parity of the word about to be driven
always @*
begin
	next_par = `SPB_ZERO_PAR;
	next_perr = `SPB_ZERO_PAR;
	for (n = 0; n < `SPB_LANES; n = n + 1)
	begin
		// lane n is bits 8n to 8n+7
		// same mapping up to lane 7
		next_par[n] = spb_odd_par(buf_data[n*`SPB_LANE_W +: `SPB_LANE_W] & mask[n*`SPB_LANE_W +: `SPB_LANE_W]);
		// group of byte and its parity must hold odd ones
		next_perr[n] = lane_on[n] & ~(^{data_parity_in[n], rd_masked[n*`SPB_LANE_W +: `SPB_LANE_W]});
	end
end

always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		state <= ST_IDLE;
		own_write <= 1'b0;
		burst <= 1'b0;
		owner_b <= 1'b0;
		drive_valid <= 1'b0;
		beat_cnt <= `SPB_BEAT_ZERO;
		cmd_ready <= 1'b0;
		tenure_done <= 1'b0;
		rd_valid <= 1'b0;
		rd_data <= `SPB_ZERO_DATA;
		rd_parity_error <= `SPB_ZERO_PAR;
		data_out <= `SPB_ZERO_DATA;
		data_oe_n <= `SPB_ALL_RELEASED_DATA;
		data_parity_out <= `SPB_ZERO_PAR;
		data_parity_oe_n <= `SPB_ALL_RELEASED_PAR;
		ext_master_grant_a <= 1'b0;
		ext_master_grant_b <= 1'b0;
		ext_master_data_grant_a <= 1'b0;
		ext_master_data_grant_b <= 1'b0;
	end
	else
	begin
		state <= next_state;
		cmd_ready <= 1'b0;
		tenure_done <= 1'b0;
		rd_valid <= 1'b0;
		if (state == ST_IDLE)
		begin
			beat_cnt <= `SPB_BEAT_ZERO;
			if (ext_master_request_a || ext_master_request_b)
			begin
				owner_b <= !ext_master_request_a;
				burst <= ext_tenure_burst;
			end
			else if (own_start)
			begin
				own_write <= cmd_write;
				burst <= cmd_burst;
				cmd_ready <= 1'b1;
			end
		end
		if (own_ack || (state == ST_EXT_DATA && transfer_ack))
		begin
			beat_cnt <= beat_cnt + `SPB_BEATS_SINGLE;
			tenure_done <= last_beat;
		end
		// we drive only as master of a write
		if (state == ST_OWN && own_write && !drive_valid && buf_valid)
		begin
			drive_valid <= 1'b1;
			data_out <= buf_data & mask;
			data_oe_n <= ~mask;
			// parity driven by whoever drives the data
			data_parity_out <= next_par;
			data_parity_oe_n <= ~lane_on;
		end
		else if (own_ack && own_write)
		begin
			// release after each beat; next word reloads a cycle later
			drive_valid <= 1'b0;
			data_oe_n <= `SPB_ALL_RELEASED_DATA;
			data_parity_oe_n <= `SPB_ALL_RELEASED_PAR;
		end
		// in our reads the slave drives, we sample on ack
		if (own_ack && !own_write)
		begin
			rd_valid <= 1'b1;
			rd_data <= rd_masked;
			rd_parity_error <= next_perr;
		end
		// address grant to the chosen master
		// grants decoded from one owner, never two
		ext_master_grant_a <= next_state == ST_EXT_ADDR && !(state == ST_IDLE ? !ext_master_request_a : owner_b);
		ext_master_grant_b <= next_state == ST_EXT_ADDR && (state == ST_IDLE ? !ext_master_request_a : owner_b);
		// data grant apart from the address grant
		ext_master_data_grant_a <= next_state == ST_EXT_DATA && !owner_b;
		ext_master_data_grant_b <= next_state == ST_EXT_DATA && owner_b;
	end
end

// host port pins; every output is zero or released while the port is off
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		host_selected <= 1'b0;
		host_width_8 <= 1'b0;
		host_read_active <= 1'b0;
		host_write_active <= 1'b0;
		host_ack_seen <= 1'b0;
		host_request_out <= 1'b0;
		host_request_oe_n <= 1'b1;
		host_receive_request_out <= 1'b0;
		host_receive_request_oe_n <= 1'b1;
	end
	else
	begin
		// select is the or of both
		host_selected <= host_port_enable & (host_select_a | host_select_b);
		host_width_8 <= host_port_enable & host_width_select;
		// one strobe plus direction, or two strobes
		// strobes seen through the polarity input
		if (host_dual_strobe_select)
		begin
			host_read_active <= host_port_enable & spb_active(host_data_strobe, host_strobe_polarity);
			host_write_active <= host_port_enable & spb_active(host_write_strobe, host_strobe_polarity);
		end
		else
		begin
			host_read_active <= host_port_enable & host_read_write &
				spb_active(host_data_strobe, host_strobe_polarity);
			host_write_active <= host_port_enable & ~host_read_write &
				spb_active(host_data_strobe, host_strobe_polarity);
		end
		// acknowledge only in single request mode
		host_ack_seen <= host_port_enable & ~host_dual_request_mode &
			spb_active(host_acknowledge, host_ack_polarity);
		// single mode: request pin carries any pending work; dual: transmit only
		host_request_out <= host_request_open_drain ? 1'b0 :
			~spb_active(~(host_dual_request_mode ? host_tx_pending : (host_tx_pending | host_rx_pending)),
			host_request_polarity);
		host_request_oe_n <= ~host_port_enable | (host_request_open_drain &
			~spb_active(~(host_dual_request_mode ? host_tx_pending : (host_tx_pending | host_rx_pending)),
			host_request_polarity));
		// receive request, driven or open drain
		host_receive_request_out <= host_request_open_drain ? 1'b0 :
			~spb_active(~host_rx_pending, host_request_polarity);
		// open drain pulls low only; the pin is released in single mode
		host_receive_request_oe_n <= ~host_port_enable | ~host_dual_request_mode |
			(host_request_open_drain & ~spb_active(~host_rx_pending, host_request_polarity));
	end
end

endmodule

/* verification/spb_far.sv */
// far side model: slave data, lane parity and transfer acknowledge
`timescale 1ns/1ns
module spb_far
(
	// bench control
	input wire clk,
	input wire go,
	input wire rd,
	input wire slow,
	input wire [2:0] beats,
	input wire [63:0] word,
	input wire [7:0] bad,
	// device pins
	input wire [63:0] data_out,
	input wire [63:0] data_oe_n,
	input wire [7:0] data_parity_out,
	input wire [7:0] data_parity_oe_n,
	output wire [63:0] data_in,
	output wire [7:0] data_parity_in,
	output logic transfer_ack = 1'b0
);
	logic [2:0] n = 3'h0;
	logic [1:0] w = 2'h0;
	logic t = 1'b0;
	logic [7:0] p;
	wire [63:0] s;
	// released lines toggle, so a stale value never reads back
	always @(posedge clk)
		t <= ~t;
	always @*
		for (int i = 0; i < 8; i++)
			p[i] = ~^word[8*i +: 8] ^ bad[i];
	assign s = rd && go ? word : {64{t}};
	assign data_in = (data_out & ~data_oe_n) | (s & data_oe_n);
	assign data_parity_in = (data_parity_out & ~data_parity_oe_n) | ((rd && go ? p : {8{~t}}) & data_parity_oe_n);
	// one ack a beat, none past the tenure
	always @(posedge clk)
		if (!go)
		begin
			n <= 3'h0;
			w <= 2'h0;
			transfer_ack <= 1'b0;
		end
		else if (transfer_ack)
			transfer_ack <= 1'b0;
		else if ((rd || !data_oe_n[0]) && n < beats)
		begin
			// slow mode stalls three cycles a beat
			if (w == {slow, slow})
			begin
				transfer_ack <= 1'b1;
				n <= n + 3'h1;
				w <= 2'h0;
			end
			else
				w <= w + 2'h1;
		end
endmodule

/* verification/spb_top_sva.sv */
// assertions on bus pins, arbiter grants and host status
`timescale 1ns/1ns
module spb_sva
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// bus
	input wire full_width_bus_only_mode,
	input wire host_port_enable,
	input wire [63:0] data_out,
	input wire [63:0] data_oe_n,
	input wire [7:0] data_parity_out,
	input wire [7:0] data_parity_oe_n,
	input wire transfer_ack,
	input wire tenure_done,
	// arbiter
	input wire ext_master_request_a,
	input wire ext_master_grant_a,
	input wire ext_master_grant_b,
	input wire ext_master_data_grant_a,
	input wire ext_master_data_grant_b,
	// host
	input wire host_select_a,
	input wire host_select_b,
	input wire host_width_select,
	input wire host_selected,
	input wire host_width_8
);
	logic [3:0] up;
	// outputs lag the internal reset copy
	always @(posedge clk or negedge nrst)
		if (!nrst)
			up <= 4'h0;
		else
			up <= {up[2:0], 1'b1};
	default clocking @(posedge clk); endclocking
	default disable iff (!up[3]);
	a_lane0_odd: assert property (!data_parity_oe_n[0] |-> data_oe_n[7:0] == 8'h00 && ^{data_parity_out[0], data_out[7:0]})
		else $error("lane 0 parity");
	a_lane4_odd: assert property (!data_parity_oe_n[4] |-> ^{data_parity_out[4], data_out[39:32]})
		else $error("lane 4 parity");
	a_top_pins_off: assert property ((!full_width_bus_only_mode || host_port_enable)[*2] |-> &data_oe_n[63:61])
		else $error("pins 61-63 driven");
	a_host_pins_off: assert property (host_port_enable[*2] |-> &data_oe_n[63:32] && &data_parity_oe_n[7:4])
		else $error("shared pins driven");
	a_one_grant: assert property (!(ext_master_grant_a && ext_master_grant_b) && !(ext_master_data_grant_a && ext_master_data_grant_b))
		else $error("two grants");
	a_grant_cause: assert property ($rose(ext_master_grant_a) |-> $past(ext_master_request_a))
		else $error("grant without request");
	a_data_grant_after: assert property ($rose(ext_master_data_grant_a) |-> $past(ext_master_grant_a) && !ext_master_grant_a)
		else $error("data grant order");
	a_tenure_end: assert property (tenure_done |-> $past(transfer_ack))
		else $error("tenure end without ack");
	a_select_or: assert property ($past(host_port_enable) |-> host_selected == $past(host_select_a | host_select_b))
		else $error("host select");
	a_width_pick: assert property ($past(host_port_enable) |-> host_width_8 == $past(host_width_select))
		else $error("host width");
endmodule
bind spb_top spb_sva chk (.*);

/* verification/tb_spb_top.sv */
// self-checking bench for the bus parity, arbiter and host pin block
`timescale 1ns/1ns
module tb_spb_top;
	logic clk = 0, nrst = 0, cmd_valid = 0, cmd_write = 0, cmd_burst = 0, wr_valid = 0, go = 0, rd = 0, slow = 0;
	logic [63:0] wr_data = 0, word = 0;
	logic [7:0] bad = 0;
	logic [2:0] beats = 0;
	logic full_width_bus_only_mode = 0, host_port_enable = 0, ext_master_request_a = 0, ext_master_request_b = 0;
	logic ext_tenure_burst = 0, host_select_a = 0, host_select_b = 0, host_width_select = 0, host_dual_strobe_select = 0;
	logic host_strobe_polarity = 0, host_data_strobe = 0, host_write_strobe = 0, host_read_write = 0, host_acknowledge = 0;
	logic host_dual_request_mode = 0, host_request_polarity = 0, host_request_open_drain = 0, host_ack_polarity = 0;
	logic host_tx_pending = 0, host_rx_pending = 0;
	wire cmd_ready, wr_ready, rd_valid, tenure_done, transfer_ack, ext_master_grant_a, ext_master_grant_b;
	wire ext_master_data_grant_a, ext_master_data_grant_b, host_selected, host_width_8, host_read_active;
	wire host_write_active, host_ack_seen, host_request_out, host_request_oe_n;
	wire host_receive_request_out, host_receive_request_oe_n;
	wire [63:0] rd_data, data_in, data_out, data_oe_n;
	wire [7:0] rd_parity_error, data_parity_in, data_parity_out, data_parity_oe_n;
	int err_total = 0, comparisons = 0, cyc = 0;
	spb_top dut (.*);
	spb_far far (.*);
	always #5 clk = ~clk;
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			give_verdict;
		end
	end
	task chk(input logic [63:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task till(input int s);
		for (int k = 0; k < 60 && !(s == 0 ? cmd_ready : s == 1 ? transfer_ack : s == 2 ? rd_valid : tenure_done); k++)
			step;
	endtask
	function logic [7:0] par(input logic [63:0] d);
		for (int i = 0; i < 8; i++)
			par[i] = ~^d[8*i +: 8];
	endfunction
	task push(input logic [63:0] d);
		wr_data = d;
		wr_valid = 1;
		for (int k = 0; k < 60 && !wr_ready; k++)
			step;
		step;
	endtask
	task cmd(input logic w, b);
		cmd_write = w;
		cmd_burst = b;
		cmd_valid = 1;
		till(0);
		cmd_valid = 0;
		go = 1;
		beats = b ? 3'h4 : 3'h1;
	endtask
	task t_write;
		logic [63:0] w[4] = '{64'h0123456789abcdef, 64'hfedcba9876543210, 64'h00000000ffffffff, 64'h8000000000000001};
		full_width_bus_only_mode = 1;
		slow = 1;
		push(w[0]);
		push(w[1]);
		wr_data = w[2];
		step(3);
		chk(wr_ready, 0);
		fork
			begin
				push(w[2]);
				push(w[3]);
				wr_valid = 0;
			end
			begin
				cmd(1, 1);
				for (int i = 0; i < 4; i++)
				begin
					till(1);
					chk(data_oe_n, 0);
					chk(data_parity_oe_n, 0);
					chk(data_out, w[i]);
					chk(data_parity_out, par(w[i]));
					step;
				end
			end
		join
		till(3);
		chk(tenure_done, 1);
		go = 0;
		slow = 0;
	endtask
	task t_read;
		full_width_bus_only_mode = 0;
		word = 64'h68e1d2c3b4a59687;
		bad = 8'h08;
		rd = 1;
		cmd(0, 1);
		for (int i = 0; i < 4; i++)
		begin
			till(2);
			chk(rd_data, 64'h08e1d2c3b4a59687);
			chk(rd_parity_error, 8'h08);
			// tenure end shows with the last read beat
			if (i == 3)
				chk(tenure_done, 1);
			step;
		end
		go = 0;
		bad = 0;
	endtask
	task t_arb;
		int n;
		ext_master_request_a = 1;
		ext_master_request_b = 1;
		step(2);
		chk({ext_master_grant_a, ext_master_grant_b}, 2'b10);
		ext_master_request_a = 0;
		step;
		chk({ext_master_data_grant_a, ext_master_grant_a}, 2'b10);
		beats = 1;
		go = 1;
		till(3);
		chk(ext_master_data_grant_a, 0);
		go = 0;
		ext_tenure_burst = 1;
		step(3);
		chk(ext_master_grant_b, 1);
		ext_master_request_b = 0;
		step;
		chk(ext_master_data_grant_b, 1);
		beats = 4;
		go = 1;
		for (n = 0; n < 60 && !tenure_done; n++)
			step;
		chk({ext_master_data_grant_b, far.n}, {1'b0, 3'h4});
		go = 0;
		rd = 0;
	endtask
	task t_host;
		logic lvl;
		logic rlvl;
		host_port_enable = 1;
		for (int i = 0; i < 4; i++)
		begin
			{host_select_b, host_select_a} = i[1:0];
			host_width_select = i[0];
			step(2);
			chk({host_selected, host_width_8}, {i[1] | i[0], i[0]});
		end
		host_select_a = 1;
		host_select_b = 0;
		host_width_select = 0;
		step(2);
		chk({data_oe_n[63:32], data_parity_oe_n[7:4]}, 36'hfffffffff);
		for (int i = 0; i < 8; i++)
		begin
			{host_strobe_polarity, host_data_strobe, host_dual_strobe_select} = i[2:0];
			host_write_strobe = ~i[2];
			host_read_write = 1;
			step(2);
			chk({host_read_active, host_write_active}, {i[1] == i[2], 1'b0});
		end
		host_write_strobe = host_strobe_polarity;
		host_data_strobe = ~host_strobe_polarity;
		step(2);
		chk(host_write_active, 1);
		for (int i = 0; i < 16; i++)
		begin
			{host_dual_request_mode, host_request_polarity, host_rx_pending, host_acknowledge} = i[3:0];
			host_ack_polarity = i[1];
			step(2);
			if (i[3])
				chk({host_receive_request_oe_n, host_receive_request_out}, {1'b0, i[2] == i[1]});
			else
				chk(host_ack_seen, i[0] == i[1]);
		end
		// request pins: wanted level is the polarity while pending, else its inverse
		for (int i = 0; i < 32; i++)
		begin
			{host_dual_request_mode, host_request_open_drain, host_request_polarity, host_tx_pending,
				host_rx_pending} = i[4:0];
			step(2);
			lvl = (i[1] | (i[0] & ~i[4])) ? i[2] : ~i[2];
			rlvl = i[0] ? i[2] : ~i[2];
			chk({host_request_out, host_request_oe_n}, i[3] ? {1'b0, lvl} : {lvl, 1'b0});
			if (i[4])
				chk({host_receive_request_out, host_receive_request_oe_n}, i[3] ? {1'b0, rlvl} : {rlvl, 1'b0});
			else
				chk(host_receive_request_oe_n, 1);
		end
		host_request_open_drain = 0;
		host_tx_pending = 0;
		host_rx_pending = 0;
		host_port_enable = 0;
		step(2);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		nrst = 1;
		step(3);
		t_write;
		step(2);
		t_read;
		step(2);
		t_arb;
		t_host;
		give_verdict;
	end
endmodule
